// [src/cpu_mode_pkg.sv]
// Shared constants and types for the CPU mode tracker and its indicator logic.
// Assumes a single 100 MHz system clock and a synchronous active-high reset.
package cpu_mode_pkg;

  // Operating modes, one-hot.
  typedef enum logic [2:0] {
    MODE_STOP    = 3'b001,
    MODE_RESTART = 3'b010,
    MODE_RUN     = 3'b100
  } mode_type;

  localparam mode_type MODE_AT_RESET = MODE_STOP;

  // Clock and flash timing.
  localparam int CLK_PERIOD_NS    = 10;
  localparam int SLOW_HALF_MS     = 500;
  localparam int FAST_HALF_MS     = 125;
  localparam int SLOW_HALF_CYCLES = SLOW_HALF_MS * 1000000 / CLK_PERIOD_NS;
  localparam int FAST_HALF_CYCLES = FAST_HALF_MS * 1000000 / CLK_PERIOD_NS;

  // Range of user handler numbers.
  localparam logic [5:0] HANDLER_FIRST = 6'h01;
  localparam logic [5:0] HANDLER_LAST  = 6'h23;

  // Bit positions in the synchronised pin vector.
  localparam int PIN_SELECTOR_STOP = 0;
  localparam int PIN_OPERATOR_RST  = 1;
  localparam int PIN_PG_STOP       = 2;
  localparam int PIN_PEER_STOP     = 3;
  localparam int PIN_COORD_RUN     = 4;
  localparam int PIN_COUNT         = 5;

  // Positions of the error kinds in the error vectors.
  localparam int ERR_IO_TIMEOUT = 0;
  localparam int ERR_ADDRESSING = 1;
  localparam int ERR_CYCLE_TIME = 2;
  localparam int ERR_COUNT      = 3;

endpackage : cpu_mode_pkg

// [src/flash_divider.sv]
// Free-running divider that makes the slow and fast indicator flash levels.
// Assumes the system clock and synchronous reset of the mode tracker.
`timescale 1ns/1ps
module flash_divider #(
  parameter int SLOW_HALF = cpu_mode_pkg::SLOW_HALF_CYCLES,
  parameter int FAST_HALF = cpu_mode_pkg::FAST_HALF_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst,
  output logic      slowFlash,
  output logic      fastFlash
);
  import cpu_mode_pkg::*;

  localparam int W = $clog2(SLOW_HALF + 1);

  typedef struct packed {
    logic [W-1:0] slowCount;
    logic [W-1:0] fastCount;
    logic         slow;
    logic         fast;
  } div_type;

  div_type s_reg;
  div_type s_next;

  always_comb begin
    s_next = s_reg;
    // Each level toggles after its half period has elapsed.
    if (s_reg.slowCount == W'(SLOW_HALF - 1)) begin
      s_next.slowCount = '0;
      s_next.slow      = ~s_reg.slow;
    end else begin
      s_next.slowCount = s_reg.slowCount + W'(1);
    end
    if (s_reg.fastCount == W'(FAST_HALF - 1)) begin
      s_next.fastCount = '0;
      s_next.fast      = ~s_reg.fast;
    end else begin
      s_next.fastCount = s_reg.fastCount + W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign slowFlash = s_reg.slow;
  assign fastFlash = s_reg.fast;

  a_slow_period: assert property (@(posedge clk) disable iff (rst)
    $changed(s_reg.slow) |-> s_reg.slowCount == '0)
    else $error("Slow flash toggled away from a period boundary.");

endmodule : flash_divider

// [src/error_indicator.sv]
// One sticky error indicator: set by a permitted detection, cleared when its handler level ends without a stop.
// Assumes detections, handler ends and the stop flag come from logic on the same clock.
`timescale 1ns/1ps
module error_indicator (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic detect,
  input  wire logic allowed,
  input  wire logic levelDone,
  input  wire logic stopping,
  output logic      lit
);
  import cpu_mode_pkg::*;

  typedef struct packed {
    logic lit;
  } ind_type;

  ind_type s_reg;
  ind_type s_next;

  always_comb begin
    s_next = s_reg;
    // A permitted detection wins over a clear in the same cycle.
    if (detect && allowed) begin
      s_next.lit = 1'b1;
    end else if (levelDone && !stopping) begin
      s_next.lit = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign lit = s_reg.lit;

  a_barred_detect: assert property (@(posedge clk) disable iff (rst)
    (!lit && !(detect && allowed)) |=> !lit)
    else $error("Error indicator lit without a permitted detection.");

  a_level_clear: assert property (@(posedge clk) disable iff (rst)
    (levelDone && !stopping && !detect) |=> !lit)
    else $error("Error indicator not cleared at end of its handler level.");

  a_detect_sets: assert property (@(posedge clk) disable iff (rst)
    (detect && allowed) |=> lit)
    else $error("Permitted detection did not light the error indicator.");

endmodule : error_indicator

// [src/cpu_mode_indicator.sv]
// Operating-mode tracker with run, stop, output-disable and error indicators.
// Assumes front-panel, programming-device, peer and coordinator inputs are asynchronous pins;
// all other inputs come from CPU logic on clk.
//
// Functional notes
// - Exactly one of stop, restart or run is held at all times.
// - In run mode the run indicator is lit and the stop indicator dark.
// - Externally requested stop keeps stop indicator steady and run indicator dark.
// - Restart mode and breakpoint wait keep both indicators dark.
// - A self-triggered stop flashes the stop indicator slowly.
// - Selector moved to stop during self stop turns slow flash into steady.
// - Pending overall reset in stop flashes stop quickly, run dark.
// - A serious system error lights both run and stop indicators.
// - Output disable drops on entering run and rises on entering stop.
// - Output disable holds through restart, stop and first run cycle after warm restart.
// - Output-disable indicator stays lit after warm restart until the remaining cycle ends.
// - Multiprocessor operation applies the same disable only with coordinator at run.
// - An I/O module timeout lights the I/O timeout indicator.
// - Access to an unpopulated process image address lights the addressing indicator.
// - Exceeding the cycle monitoring time lights the cycle error indicator.
// - Addressing and timeout errors only in restart or run; cycle errors only in run.
// - Finishing an error handler level without stopping clears its indicator.
// - In restart and run, each event numbered 1 to 35 calls its numbered user handler.
// - The user program does not execute in stop mode.
`timescale 1ns/1ps
module cpu_mode_indicator #(
  parameter int SLOW_HALF = cpu_mode_pkg::SLOW_HALF_CYCLES,
  parameter int FAST_HALF = cpu_mode_pkg::FAST_HALF_CYCLES
) (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   selectorStop,
  input  wire logic                   operatorResetReq,
  input  wire logic                   pgStopReq,
  input  wire logic                   peerStopReq,
  input  wire logic                   coordinatorRun,
  input  wire logic                   multiProcessor,
  input  wire logic                   selfStopReq,
  input  wire logic                   selfResetReq,
  input  wire logic                   overallResetDone,
  input  wire logic                   restartReq,
  input  wire logic                   restartWarm,
  input  wire logic                   restartDone,
  input  wire logic                   cycleEnd,
  input  wire logic                   breakpointWait,
  input  wire logic                   seriousError,
  input  wire logic                   ioTimeoutDetect,
  input  wire logic                   addressingDetect,
  input  wire logic                   cycleTimeDetect,
  input  wire logic [2:0]             errorLevelDone,
  input  wire logic                   eventValid,
  input  wire logic [5:0]             eventBlock,
  output cpu_mode_pkg::mode_type      modeState,
  output logic                        runLed,
  output logic                        stopLed,
  output logic                        cmdOutputDisable,
  output logic                        cmdOutputDisableLed,
  output logic                        ioTimeoutLed,
  output logic                        addressingLed,
  output logic                        cycleErrorLed,
  output logic                        programEnable,
  output logic                        handlerCall,
  output logic [5:0]                  handlerNumber
);
  import cpu_mode_pkg::*;

  typedef struct packed {
    logic [PIN_COUNT-1:0] sync1;
    logic [PIN_COUNT-1:0] sync2;
    logic                 selectorPrev;
    mode_type             mode;
    logic                 selfStop;
    logic                 resetPending;
    logic                 warmStart;
    logic                 warmPending;
    logic                 runLed;
    logic                 stopLed;
    logic                 outDisable;
    logic                 programEnable;
    logic                 handlerCall;
    logic [5:0]           handlerNumber;
  } state_type;

  state_type s_reg;
  state_type s_next;

  logic                 slowFlash;
  logic                 fastFlash;
  logic                 selStop;
  logic                 extStop;
  logic                 overallReq;
  logic                 coordOk;
  logic                 stopping;
  logic [ERR_COUNT-1:0] errDetect;
  logic [ERR_COUNT-1:0] errAllowed;
  logic [ERR_COUNT-1:0] errLit;

  flash_divider #(
    .SLOW_HALF (SLOW_HALF),
    .FAST_HALF (FAST_HALF)
  ) flashGen (
    .clk       (clk),
    .rst       (rst),
    .slowFlash (slowFlash),
    .fastFlash (fastFlash)
  );

  always_comb begin
    s_next       = s_reg;
    s_next.sync1 = {coordinatorRun, peerStopReq, pgStopReq, operatorResetReq, selectorStop};
    s_next.sync2 = s_reg.sync1;
    selStop      = s_reg.sync2[PIN_SELECTOR_STOP];
    extStop      = selStop | s_reg.sync2[PIN_PG_STOP] | s_reg.sync2[PIN_PEER_STOP];
    overallReq   = s_reg.sync2[PIN_OPERATOR_RST] | selfResetReq;
    // In multiprocessor operation with the coordinator in test mode the disable is never driven.
    coordOk      = !multiProcessor || s_reg.sync2[PIN_COORD_RUN];
    s_next.selectorPrev = selStop;

    case (s_reg.mode)
      MODE_STOP: begin
        if (overallResetDone) begin
          s_next.resetPending = 1'b0;
        end
        if (overallReq) begin
          s_next.resetPending = 1'b1;
        end
        if (selStop && !s_reg.selectorPrev) begin
          s_next.selfStop = 1'b0;
        end
        if (restartReq && !extStop && !s_reg.resetPending && !overallReq) begin
          s_next.mode      = MODE_RESTART;
          s_next.warmStart = restartWarm;
          s_next.selfStop  = 1'b0;
        end
      end
      MODE_RESTART, MODE_RUN: begin
        if (cycleEnd) begin
          s_next.warmPending = 1'b0;
        end
        if (selfStopReq || overallReq) begin
          s_next.mode         = MODE_STOP;
          s_next.selfStop     = selfStopReq | selfResetReq;
          s_next.resetPending = overallReq;
          s_next.warmPending  = 1'b0;
        end else if (extStop) begin
          s_next.mode        = MODE_STOP;
          s_next.selfStop    = 1'b0;
          s_next.warmPending = 1'b0;
        end else if (s_reg.mode == MODE_RESTART && restartDone) begin
          s_next.mode        = MODE_RUN;
          s_next.warmPending = s_reg.warmStart;
        end
      end
      default: begin
        s_next.mode = MODE_STOP;
      end
    endcase

    // Indicators follow the mode being entered so they change with it.
    if (seriousError) begin
      s_next.runLed  = 1'b1;
      s_next.stopLed = 1'b1;
    end else begin
      case (s_next.mode)
        MODE_RUN: begin
          s_next.runLed  = !breakpointWait;
          s_next.stopLed = 1'b0;
        end
        MODE_STOP: begin
          s_next.runLed = 1'b0;
          if (s_next.resetPending) begin
            s_next.stopLed = fastFlash;
          end else if (s_next.selfStop) begin
            s_next.stopLed = slowFlash;
          end else begin
            s_next.stopLed = 1'b1;
          end
        end
        default: begin
          s_next.runLed  = 1'b0;
          s_next.stopLed = 1'b0;
        end
      endcase
    end

    s_next.outDisable = coordOk && (s_next.mode != MODE_RUN || s_next.warmPending);
    s_next.programEnable = s_next.mode != MODE_STOP;
    s_next.handlerCall = eventValid && s_reg.mode != MODE_STOP
                         && eventBlock >= HANDLER_FIRST && eventBlock <= HANDLER_LAST;
    if (s_next.handlerCall) begin
      s_next.handlerNumber = eventBlock;
    end
    stopping = s_next.mode == MODE_STOP;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg         <= '0;
      s_reg.mode    <= MODE_AT_RESET;
      s_reg.stopLed <= 1'b1;
      s_reg.outDisable <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign errDetect[ERR_IO_TIMEOUT]  = ioTimeoutDetect;
  assign errDetect[ERR_ADDRESSING]  = addressingDetect;
  assign errDetect[ERR_CYCLE_TIME]  = cycleTimeDetect;
  assign errAllowed[ERR_IO_TIMEOUT] = s_reg.mode != MODE_STOP;
  assign errAllowed[ERR_ADDRESSING] = s_reg.mode != MODE_STOP;
  assign errAllowed[ERR_CYCLE_TIME] = s_reg.mode == MODE_RUN;

  generate
    for (genvar i = 0; i < ERR_COUNT; i++) begin : gErr
      error_indicator errInd (
        .clk       (clk),
        .rst       (rst),
        .detect    (errDetect[i]),
        .allowed   (errAllowed[i]),
        .levelDone (errorLevelDone[i]),
        .stopping  (stopping),
        .lit       (errLit[i])
      );
    end
  endgenerate

  assign modeState           = s_reg.mode;
  assign runLed              = s_reg.runLed;
  assign stopLed             = s_reg.stopLed;
  assign cmdOutputDisable    = s_reg.outDisable;
  assign cmdOutputDisableLed = s_reg.outDisable;
  assign ioTimeoutLed        = errLit[ERR_IO_TIMEOUT];
  assign addressingLed       = errLit[ERR_ADDRESSING];
  assign cycleErrorLed       = errLit[ERR_CYCLE_TIME];
  assign programEnable       = s_reg.programEnable;
  assign handlerCall         = s_reg.handlerCall;
  assign handlerNumber       = s_reg.handlerNumber;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence selfStopped;
    s_reg.mode == MODE_STOP && s_reg.selfStop && !s_reg.resetPending;
  endsequence

  sequence selectorMoved;
    selStop && !s_reg.selectorPrev && !restartReq;
  endsequence

  a_one_mode: assert property ($onehot(s_reg.mode))
    else $error("Mode register is not one-hot.");

  a_run_leds: assert property (
    (s_next.mode == MODE_RUN && !seriousError && !breakpointWait) |=> (runLed && !stopLed))
    else $error("Run mode indicators wrong.");

  a_ext_stop_steady: assert property (
    (s_next.mode == MODE_STOP && !s_next.selfStop && !s_next.resetPending && !seriousError)
    |=> (stopLed && !runLed))
    else $error("Externally requested stop not shown steady.");

  a_restart_dark: assert property (
    (s_next.mode == MODE_RESTART && !seriousError) |=> (!runLed && !stopLed))
    else $error("Restart mode indicators not dark.");

  a_slow_flash: assert property (
    (s_next.mode == MODE_STOP && s_next.selfStop && !s_next.resetPending && !seriousError)
    |=> (stopLed == $past(slowFlash) && !runLed))
    else $error("Self-triggered stop not flashing slowly.");

  a_selector_steady: assert property (
    (selfStopped ##0 selectorMoved) |=> (s_reg.mode == MODE_STOP && !s_reg.selfStop))
    else $error("Selector at stop did not end the slow flash.");

  a_reset_fast: assert property (
    (s_next.mode == MODE_STOP && s_next.resetPending && !seriousError)
    |=> (stopLed == $past(fastFlash) && !runLed))
    else $error("Pending overall reset not flashing fast.");

  a_serious_both: assert property (seriousError |=> (runLed && stopLed))
    else $error("Serious error did not light both indicators.");

  a_disable_modes: assert property (
    (s_next.mode != MODE_RUN && coordOk) |=> cmdOutputDisable)
    else $error("Output disable released outside run.");

  a_run_release: assert property (
    (s_next.mode == MODE_RUN && !s_next.warmPending) |=> !cmdOutputDisable)
    else $error("Output disable held in run without a warm restart cycle.");

  a_warm_hold: assert property (
    (s_reg.mode == MODE_RUN && s_reg.warmPending && !cycleEnd && coordOk && !extStop)
    |=> cmdOutputDisableLed)
    else $error("Output disable indicator dropped before the remaining cycle ended.");

  a_coord_test: assert property ((multiProcessor && !s_reg.sync2[PIN_COORD_RUN]) |=> !cmdOutputDisable)
    else $error("Output disable driven while coordinator is in test mode.");

  a_handler_call: assert property (
    (eventValid && s_reg.mode != MODE_STOP && eventBlock >= HANDLER_FIRST && eventBlock <= HANDLER_LAST)
    |=> (handlerCall && handlerNumber == $past(eventBlock)))
    else $error("Event did not call its handler.");

  a_stop_no_program: assert property (
    (s_reg.mode == MODE_STOP) |=> (s_reg.mode != MODE_STOP || (!programEnable && !handlerCall)))
    else $error("Program enabled in stop mode.");

endmodule : cpu_mode_indicator

// [bench/panel_model.sv]
// Front panel, programming device, peer CPU and coordinator pins plus one digital output module.
// Assumes the bench calls setPin just after a rising clock edge of the mode tracker's clock.
`timescale 1ns/1ps
module panel_model (
  input  wire logic       cmdOutputDisable,
  input  wire logic [7:0] outImage,
  output logic            selectorStop,
  output logic            operatorResetReq,
  output logic            pgStopReq,
  output logic            peerStopReq,
  output logic            coordinatorRun,
  output logic [7:0]      outPins
);
  import cpu_mode_pkg::*;

  initial begin
    selectorStop     = 1'b0;
    operatorResetReq = 1'b0;
    pgStopReq        = 1'b0;
    peerStopReq      = 1'b0;
    coordinatorRun   = 1'b1;
  end

  // Pins are levels held by the operator until moved again.
  task automatic setPin(input int idx, input logic v);
    case (idx)
      PIN_SELECTOR_STOP: selectorStop <= v;
      PIN_OPERATOR_RST:  operatorResetReq <= v;
      PIN_PG_STOP:       pgStopReq <= v;
      PIN_PEER_STOP:     peerStopReq <= v;
      default:           coordinatorRun <= v;
    endcase
  endtask : setPin

  assign outPins = cmdOutputDisable ? 8'h00 : outImage;
endmodule : panel_model

// [bench/cpu_mode_indicator_test.sv]
// Self-checking bench for the mode tracker and its indicators.
// Assumes short flash parameters and the panel model driving the asynchronous pins.
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin badCount++; $display("Error at %0t: got %0h expected %0h", $time, (a), (b)); end end
`define PULSE(s) begin @(posedge clk); s <= 1'b1; @(posedge clk); s <= 1'b0; #1; end
module cpu_mode_indicator_test;
  import cpu_mode_pkg::*;
  localparam int SLOW = 8;
  localparam int FAST = 2;
  logic clk = 0, rst = 1, multiProcessor = 0, selfStopReq = 0, selfResetReq = 0, overallResetDone = 0;
  logic restartReq = 0, restartWarm = 0, restartDone = 0, cycleEnd = 0, breakpointWait = 0, seriousError = 0;
  logic ioTimeoutDetect = 0, addressingDetect = 0, cycleTimeDetect = 0, eventValid = 0;
  logic [2:0] errorLevelDone = 3'h0;
  logic [5:0] eventBlock = 6'h00;
  logic [7:0] outImage = 8'ha5;
  logic [7:0] outPins;
  logic       selectorStop, operatorResetReq, pgStopReq, peerStopReq, coordinatorRun;
  logic       runLed, stopLed, cmdOutputDisable, cmdOutputDisableLed, ioTimeoutLed, addressingLed;
  logic       cycleErrorLed, programEnable, handlerCall;
  logic [5:0] handlerNumber;
  mode_type   modeState;
  int         badCount = 0, checks = 0, cycles = 0, n;

  always #5 clk = ~clk;

  cpu_mode_indicator #(.SLOW_HALF(SLOW), .FAST_HALF(FAST)) DUT (.clk(clk), .rst(rst),
    .selectorStop(selectorStop), .operatorResetReq(operatorResetReq), .pgStopReq(pgStopReq),
    .peerStopReq(peerStopReq), .coordinatorRun(coordinatorRun), .multiProcessor(multiProcessor),
    .selfStopReq(selfStopReq), .selfResetReq(selfResetReq), .overallResetDone(overallResetDone),
    .restartReq(restartReq), .restartWarm(restartWarm), .restartDone(restartDone), .cycleEnd(cycleEnd),
    .breakpointWait(breakpointWait), .seriousError(seriousError), .ioTimeoutDetect(ioTimeoutDetect),
    .addressingDetect(addressingDetect), .cycleTimeDetect(cycleTimeDetect), .errorLevelDone(errorLevelDone),
    .eventValid(eventValid), .eventBlock(eventBlock), .modeState(modeState), .runLed(runLed),
    .stopLed(stopLed), .cmdOutputDisable(cmdOutputDisable), .cmdOutputDisableLed(cmdOutputDisableLed),
    .ioTimeoutLed(ioTimeoutLed), .addressingLed(addressingLed), .cycleErrorLed(cycleErrorLed),
    .programEnable(programEnable), .handlerCall(handlerCall), .handlerNumber(handlerNumber));

  panel_model panel (.cmdOutputDisable(cmdOutputDisable), .outImage(outImage), .selectorStop(selectorStop),
    .operatorResetReq(operatorResetReq), .pgStopReq(pgStopReq), .peerStopReq(peerStopReq),
    .coordinatorRun(coordinatorRun), .outPins(outPins));

  task automatic final_report();
    if (badCount == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      badCount++;
      final_report();
    end
  end

  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick

  // Pins pass a two-stage synchroniser, so a few cycles are allowed for them.
  task automatic pin(input int idx, input logic v);
    @(posedge clk);
    panel.setPin(idx, v);
    repeat (4) tick();
  endtask : pin

  // Counts cycles between two consecutive changes of the stop indicator.
  task automatic measureHalf(output int h);
    logic last;
    int   k;
    h = 0;
    last = stopLed;
    for (k = 0; k < 40 && stopLed === last; k++) tick();
    last = stopLed;
    for (k = 0; k < 40 && stopLed === last; k++) begin
      tick();
      h++;
    end
  endtask : measureHalf

  task automatic checkReset();
    `CHK(modeState, MODE_STOP);
    `CHK({runLed, stopLed, cmdOutputDisable}, 3'b011);
    `CHK({ioTimeoutLed, addressingLed, cycleErrorLed, programEnable, handlerCall}, 5'h00);
    `CHK(outPins, 8'h00);
  endtask : checkReset

  // The warm flag is presented in the same cycle as the restart request.
  task automatic toRun(input logic warm);
    @(posedge clk);
    restartWarm <= warm;
    restartReq  <= 1'b1;
    @(posedge clk);
    restartReq  <= 1'b0;
    #1;
    `CHK(modeState, MODE_RESTART);
    `CHK({runLed, stopLed, cmdOutputDisable}, 3'b001);
    `PULSE(restartDone)
    `CHK({runLed, stopLed}, 2'b10);
    `CHK({cmdOutputDisable, cmdOutputDisableLed}, {warm, warm});
    `CHK(outPins, warm ? 8'h00 : 8'ha5);
    if (warm) begin
      `PULSE(cycleEnd)
      `CHK({cmdOutputDisable, cmdOutputDisableLed}, 2'b00);
    end
  endtask : toRun

  // Starts in stop with the timeout indicator still lit from the self-stop scenario.
  task automatic errorsAndHandlers();
    int b;
    `PULSE(addressingDetect)
    `CHK(addressingLed, 1'b0);
    `PULSE(restartReq)
    `PULSE(errorLevelDone[0])
    `CHK(ioTimeoutLed, 1'b0);
    `PULSE(cycleTimeDetect)
    `CHK(cycleErrorLed, 1'b0);
    `PULSE(addressingDetect)
    `CHK(addressingLed, 1'b1);
    `PULSE(restartDone)
    `PULSE(ioTimeoutDetect)
    `CHK(ioTimeoutLed, 1'b1);
    `PULSE(cycleTimeDetect)
    `CHK(cycleErrorLed, 1'b1);
    @(posedge clk);
    errorLevelDone <= 3'h7;
    @(posedge clk);
    errorLevelDone <= 3'h0;
    #1;
    `CHK({ioTimeoutLed, addressingLed, cycleErrorLed}, 3'b000);
    `CHK(programEnable, 1'b1);
    for (b = 0; b < 37; b += (b == 1) ? 34 : 1) begin
      @(posedge clk);
      eventValid <= 1'b1;
      eventBlock <= b[5:0];
      @(posedge clk);
      eventValid <= 1'b0;
      #1;
      `CHK(handlerCall, (b >= 1 && b <= 35));
      if (b >= 1 && b <= 35) `CHK(handlerNumber, b[5:0]);
    end
  endtask : errorsAndHandlers

  task automatic selfStop();
    `PULSE(ioTimeoutDetect)
    `CHK(ioTimeoutLed, 1'b1);
    `PULSE(selfStopReq)
    `CHK(modeState, MODE_STOP);
    `CHK({runLed, cmdOutputDisable, programEnable}, 3'b010);
    `PULSE(errorLevelDone[0])
    `CHK(ioTimeoutLed, 1'b1);
    measureHalf(n);
    `CHK(n, SLOW);
    pin(PIN_SELECTOR_STOP, 1'b1);
    repeat (12) begin
      tick();
      `CHK(stopLed, 1'b1);
    end
    `PULSE(restartReq)
    `CHK(modeState, MODE_STOP);
    pin(PIN_SELECTOR_STOP, 1'b0);
  endtask : selfStop

  // Operator request first, then a request raised by the CPU itself.
  task automatic overallReset();
    pin(PIN_OPERATOR_RST, 1'b1);
    measureHalf(n);
    `CHK(n, FAST);
    `CHK(runLed, 1'b0);
    pin(PIN_OPERATOR_RST, 1'b0);
    `PULSE(overallResetDone)
    `CHK(stopLed, 1'b1);
    `PULSE(selfResetReq)
    measureHalf(n);
    `CHK(n, FAST);
    `PULSE(overallResetDone)
    `CHK(stopLed, 1'b1);
  endtask : overallReset

  // Starts in run, so a self stop brings the tracker to stop before the first restart; each external stop precedes the next.
  task automatic externalStops();
    int idx;
    `PULSE(selfStopReq)
    `CHK(modeState, MODE_STOP);
    `PULSE(ioTimeoutDetect)
    `CHK(ioTimeoutLed, 1'b0);
    for (idx = PIN_SELECTOR_STOP; idx <= PIN_PEER_STOP; idx++) begin
      if (idx == PIN_OPERATOR_RST) continue;
      toRun(1'b0);
      pin(idx, 1'b1);
      `CHK(modeState, MODE_STOP);
      repeat (10) begin
        tick();
        `CHK({runLed, stopLed, cmdOutputDisable}, 3'b011);
      end
      pin(idx, 1'b0);
    end
  endtask : externalStops

  task automatic overrides();
    toRun(1'b1);
    @(posedge clk);
    breakpointWait <= 1'b1;
    repeat (2) tick();
    `CHK({runLed, stopLed}, 2'b00);
    @(posedge clk);
    breakpointWait <= 1'b0;
    seriousError   <= 1'b1;
    repeat (2) tick();
    `CHK({runLed, stopLed}, 2'b11);
    @(posedge clk);
    seriousError   <= 1'b0;
    multiProcessor <= 1'b1;
    repeat (2) tick();
    `CHK({runLed, stopLed}, 2'b10);
    `CHK(cmdOutputDisable, 1'b0);
    `PULSE(selfStopReq)
    `CHK(cmdOutputDisable, 1'b1);
    pin(PIN_COORD_RUN, 1'b0);
    `CHK(cmdOutputDisable, 1'b0);
    pin(PIN_COORD_RUN, 1'b1);
    @(posedge clk);
    multiProcessor <= 1'b0;
  endtask : overrides

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    tick();
    checkReset();
    toRun(1'b0);
    selfStop();
    overallReset();
    errorsAndHandlers();
    externalStops();
    overrides();
    final_report();
  end
endmodule : cpu_mode_indicator_test
